// >>> include/mirq_pkg.sv
// package: register map, field layout, reset values and timing counts of the interrupt block
package mirq_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_RANGE_SEL    = 8'h0f;
    localparam logic [7:0] ADDR_SOURCE_SEL   = 8'h16;
    localparam logic [7:0] ADDR_READY_EN     = 8'h17;
    localparam logic [7:0] ADDR_MOTION_ROUTE = 8'h19;
    localparam logic [7:0] ADDR_READY_ROUTE  = 8'h1a;
    localparam logic [7:0] ADDR_PIN_CONFIG   = 8'h20;
    localparam logic [7:0] ADDR_HOLD_TIME    = 8'h21;
    localparam logic [7:0] ADDR_DURATION     = 8'h27;
    localparam logic [7:0] ADDR_THRESHOLD    = 8'h28;
    localparam logic [7:0] ADDR_MOTION_FLAG  = 8'h09;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int BIT_READY_ROUTE  = 0;
    localparam int BIT_MOTION_ROUTE = 2;
    localparam int BIT_MOTION_FLAG  = 2;
    localparam int BIT_READY_EN     = 4;
    localparam int BIT_POLARITY     = 0;
    localparam int BIT_DRAIN        = 1;
    localparam int BIT_CLEAR_HELD   = 7;
    localparam int POS_SOURCE_SEL   = 6;
    localparam int POS_MOTION_CNT   = 0;
    localparam int POS_QUIET_CNT    = 4;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_READY_ROUTE = 8'h00;
    localparam logic [7:0] RST_PIN_CONFIG  = 8'h01;
    localparam logic [7:0] RST_HOLD_TIME   = 8'h00;
    localparam logic [7:0] RST_DURATION    = 8'h00;
    localparam logic [7:0] RST_THRESHOLD   = 8'h14;
    localparam logic [7:0] RST_RANGE       = 8'h00;
    localparam logic [7:0] RST_MISC        = 8'h00;

    // ---------------------------------------------------------------
    // range factors in thousandths of a milli-g per threshold step
    // ---------------------------------------------------------------
    localparam logic [13:0] FACTOR_2G = 14'h0f46; // 3.910 mg
    localparam logic [13:0] FACTOR_4G = 14'h1e82; // 7.810 mg
    localparam logic [13:0] FACTOR_8G = 14'h3d09; // 15.625 mg

    // ---------------------------------------------------------------
    // timing: base tick of 1 ms derived from the 200 MHz clock
    // ---------------------------------------------------------------
    localparam int CLK_MHZ     = 200;
    localparam int TICK_US     = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    // hold times in ms for codes 0..15; 0 = none, all ones = permanent
    localparam logic [13:0] HOLD_NONE = 14'h0000;
    localparam logic [13:0] HOLD_PERM = 14'h3fff;
    localparam logic [13:0] HOLD_MS [16] = '{
        14'h0000, 14'h00fa, 14'h01f4, 14'h03e8, 14'h07d0, 14'h0fa0, 14'h1f40, 14'h3fff,
        14'h0000, 14'h0001, 14'h0001, 14'h0002, 14'h0019, 14'h0032, 14'h0064, 14'h3fff};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HELD = 2'b01,
        ST_PERM = 2'b10
    } mirq_hold_state_type;

endpackage

// >>> rtl/mirq_counter.sv
// duration counter: consecutive-sample qualifier for activity and inactivity
`timescale 1ns/10ps
module mirq_counter (
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_sample,
    input  wire logic       i_cond,
    input  wire logic [3:0] i_count,
    output logic            o_hit
);
    typedef struct packed {
        logic [4:0] run;
        logic       hit;
    } mirq_cnt_state_type;

    mirq_cnt_state_type state_reg;
    mirq_cnt_state_type state_next;

    // the run saturates one above the limit so a long condition does not wrap
    always_comb begin
        state_next = state_reg;
        if (i_sample) begin
            if (i_cond) begin
                if (state_reg.run <= {1'b0, i_count}) begin
                    state_next.run = state_reg.run + 5'h01;
                end
            end else begin
                state_next.run = 5'h00;
            end
        end
        state_next.hit = (state_next.run > {1'b0, i_count});
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_hit = state_reg.hit;
endmodule

// >>> rtl/mirq_top.sv
// interrupt routing, hold-time latch and activity qualification of the motion sensor
`timescale 1ns/10ps

module mirq_top (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_rate_tick,
    input  wire logic        i_fast_tick,
    input  wire logic        i_new_data,
    input  wire logic        i_above_thr,
    output logic      [7:0]  o_rdata,
    output logic             o_int_out,
    output logic             o_int_oe,
    output logic             o_active,
    output logic             o_inactive,
    output logic      [21:0] o_thr_umg
);
    typedef struct packed {
        logic [7:0]                   ready_route;
        logic [7:0]                   motion_route;
        logic [7:0]                   ready_en;
        logic [7:0]                   source_sel;
        logic [7:0]                   range_sel;
        logic [7:0]                   pin_cfg;
        logic [7:0]                   hold_code;
        logic [7:0]                   duration;
        logic [7:0]                   threshold;
        logic                         motion_flag;
        logic                         act_prev;
        mirq_pkg::mirq_hold_state_type hold_st;
        logic [13:0]                  hold_ms;
        logic [31:0]                  tick_cnt;
        logic [7:0]                   rdata;
        logic                         pin_out;
        logic                         pin_oe;
        logic                         active;
        logic                         inactive;
        logic [21:0]                  thr_umg;
    } mirq_state_type;

    mirq_state_type state_reg;
    mirq_state_type state_next;
    logic           act_hit;
    logic           quiet_hit;
    logic           sample;

    function automatic logic [13:0] range_factor(input logic [1:0] full_scale_sel);
        case (full_scale_sel)
            2'b00:   range_factor = mirq_pkg::FACTOR_2G;
            2'b01:   range_factor = mirq_pkg::FACTOR_4G;
            default: range_factor = mirq_pkg::FACTOR_8G;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // duration qualification
    // ---------------------------------------------------------------
    assign sample = (state_reg.source_sel[mirq_pkg::POS_SOURCE_SEL +: 2] == 2'b00)
                    ? i_fast_tick : i_rate_tick;

    mirq_counter u_act (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_sample (sample),
        .i_cond   (i_above_thr),
        .i_count  (state_reg.duration[mirq_pkg::POS_MOTION_CNT +: 4]),
        .o_hit    (act_hit)
    );

    mirq_counter u_quiet (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_sample (sample),
        .i_cond   (!i_above_thr),
        .i_count  (state_reg.duration[mirq_pkg::POS_QUIET_CNT +: 4]),
        .o_hit    (quiet_hit)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic        ready_irq;
        logic        act_irq;
        logic        src;
        logic        clear;
        logic        asserted;
        logic [13:0] hold;
        ready_irq  = 1'b0;
        act_irq    = 1'b0;
        src        = 1'b0;
        clear      = 1'b0;
        asserted   = 1'b0;
        hold       = mirq_pkg::HOLD_NONE;
        state_next = state_reg;

        clear = i_wr_en && (i_addr == mirq_pkg::ADDR_PIN_CONFIG)
                && i_wdata[mirq_pkg::BIT_CLEAR_HELD];
        if (i_wr_en) begin
            case (i_addr)
                mirq_pkg::ADDR_READY_ROUTE:  state_next.ready_route  = i_wdata;
                mirq_pkg::ADDR_MOTION_ROUTE: state_next.motion_route = i_wdata;
                mirq_pkg::ADDR_READY_EN:     state_next.ready_en     = i_wdata;
                mirq_pkg::ADDR_SOURCE_SEL:   state_next.source_sel   = i_wdata;
                mirq_pkg::ADDR_RANGE_SEL:    state_next.range_sel    = i_wdata;
                mirq_pkg::ADDR_PIN_CONFIG:   state_next.pin_cfg      = {1'b0, i_wdata[6:0]};
                mirq_pkg::ADDR_HOLD_TIME:    state_next.hold_code    = i_wdata;
                mirq_pkg::ADDR_DURATION:     state_next.duration     = i_wdata;
                mirq_pkg::ADDR_THRESHOLD:    state_next.threshold    = i_wdata;
                default: ;
            endcase
        end

        // sources and routing
        ready_irq = i_new_data && state_reg.ready_en[mirq_pkg::BIT_READY_EN]
                    && state_reg.ready_route[mirq_pkg::BIT_READY_ROUTE];
        act_irq   = act_hit && state_reg.motion_route[mirq_pkg::BIT_MOTION_ROUTE];
        src       = ready_irq || act_irq;

        // motion flag: a new activity event wins over the clear
        state_next.act_prev = act_hit;
        if (clear) begin
            state_next.motion_flag = 1'b0;
        end
        if (act_hit && !state_reg.act_prev) begin
            state_next.motion_flag = 1'b1;
        end

        // hold-time latch
        hold = mirq_pkg::HOLD_MS[state_reg.hold_code[3:0]];
        if (state_reg.tick_cnt >= 32'(mirq_pkg::TICK_CYCLES - 1)) begin
            state_next.tick_cnt = 32'h0000_0000;
        end else begin
            state_next.tick_cnt = state_reg.tick_cnt + 32'h0000_0001;
        end
        case (state_reg.hold_st)
            mirq_pkg::ST_IDLE: begin
                if (src && hold == mirq_pkg::HOLD_PERM) begin
                    state_next.hold_st = mirq_pkg::ST_PERM;
                end else if (src && hold != mirq_pkg::HOLD_NONE) begin
                    state_next.hold_st  = mirq_pkg::ST_HELD;
                    state_next.hold_ms  = hold;
                    state_next.tick_cnt = 32'h0000_0000;
                end
            end
            mirq_pkg::ST_HELD: begin
                if (clear) begin
                    state_next.hold_st = mirq_pkg::ST_IDLE;
                end else if (state_reg.tick_cnt >= 32'(mirq_pkg::TICK_CYCLES - 1)) begin
                    if (state_reg.hold_ms <= 14'h0001) begin
                        state_next.hold_st = mirq_pkg::ST_IDLE;
                    end
                    state_next.hold_ms = state_reg.hold_ms - 14'h0001;
                end
            end
            mirq_pkg::ST_PERM: begin
                if (clear) begin
                    state_next.hold_st = mirq_pkg::ST_IDLE;
                end
            end
            default: state_next.hold_st = mirq_pkg::ST_IDLE;
        endcase
        asserted = src || (state_reg.hold_st != mirq_pkg::ST_IDLE);

        // pin drive: open-drain only pulls low; polarity 0 pulls while asserted, polarity 1 while deasserted
        if (state_reg.pin_cfg[mirq_pkg::BIT_DRAIN]) begin
            state_next.pin_out = 1'b0;
            state_next.pin_oe  = (asserted != state_reg.pin_cfg[mirq_pkg::BIT_POLARITY]);
        end else begin
            state_next.pin_out = (asserted == state_reg.pin_cfg[mirq_pkg::BIT_POLARITY]);
            state_next.pin_oe  = 1'b1;
        end

        state_next.active   = act_hit;
        state_next.inactive = quiet_hit;
        // widen both operands first so the product is not cut to 14 bits
        state_next.thr_umg  = 22'(state_reg.threshold)
                              * 22'(range_factor(state_reg.range_sel[1:0]));

        // read back
        state_next.rdata = 8'h00;
        if (i_rd_en) begin
            case (i_addr)
                mirq_pkg::ADDR_READY_ROUTE:  state_next.rdata = state_reg.ready_route;
                mirq_pkg::ADDR_MOTION_ROUTE: state_next.rdata = state_reg.motion_route;
                mirq_pkg::ADDR_READY_EN:     state_next.rdata = state_reg.ready_en;
                mirq_pkg::ADDR_SOURCE_SEL:   state_next.rdata = state_reg.source_sel;
                mirq_pkg::ADDR_RANGE_SEL:    state_next.rdata = state_reg.range_sel;
                mirq_pkg::ADDR_PIN_CONFIG:   state_next.rdata = state_reg.pin_cfg;
                mirq_pkg::ADDR_HOLD_TIME:    state_next.rdata = state_reg.hold_code;
                mirq_pkg::ADDR_DURATION:     state_next.rdata = state_reg.duration;
                mirq_pkg::ADDR_THRESHOLD:    state_next.rdata = state_reg.threshold;
                mirq_pkg::ADDR_MOTION_FLAG:
                    state_next.rdata = 8'(state_reg.motion_flag) << mirq_pkg::BIT_MOTION_FLAG;
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg              <= '0;
            state_reg.ready_route  <= mirq_pkg::RST_READY_ROUTE;
            state_reg.motion_route <= mirq_pkg::RST_MISC;
            state_reg.ready_en     <= mirq_pkg::RST_MISC;
            state_reg.source_sel   <= mirq_pkg::RST_MISC;
            state_reg.range_sel    <= mirq_pkg::RST_RANGE;
            state_reg.pin_cfg      <= mirq_pkg::RST_PIN_CONFIG;
            state_reg.hold_code    <= mirq_pkg::RST_HOLD_TIME;
            state_reg.duration     <= mirq_pkg::RST_DURATION;
            state_reg.threshold    <= mirq_pkg::RST_THRESHOLD;
            state_reg.hold_st      <= mirq_pkg::ST_IDLE;
            state_reg.pin_oe       <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rdata    = state_reg.rdata;
    assign o_int_out  = state_reg.pin_out;
    assign o_int_oe   = state_reg.pin_oe;
    assign o_active   = state_reg.active;
    assign o_inactive = state_reg.inactive;
    assign o_thr_umg  = state_reg.thr_umg;
endmodule

// >>> testbench/mirq_top_properties.sv
// checker: concurrent properties on the ports of the interrupt block
`timescale 1ns/10ps
module mirq_chk (
    input wire logic        i_clk,
    input wire logic        i_arst_n,
    input wire logic        i_wr_en,
    input wire logic        i_rd_en,
    input wire logic [7:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_rate_tick,
    input wire logic        i_fast_tick,
    input wire logic        i_new_data,
    input wire logic        i_above_thr,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_int_out,
    input wire logic        o_int_oe,
    input wire logic        o_active,
    input wire logic        o_inactive,
    input wire logic [21:0] o_thr_umg
);
    // ---------------------------------------------------------------
    // shadow of the configuration
    // ---------------------------------------------------------------
    // outputs lag a write by up to two edges, so judge only after three quiet cycles
    logic [7:0]  thr_reg;
    logic [1:0]  rng_reg;
    logic [1:0]  cfg_reg;
    logic [3:0]  hold_reg;
    logic        rte_reg;
    logic        mrte_reg;
    logic        ren_reg;
    logic [1:0]  age_reg;
    logic [13:0] fac;
    logic        steady;
    logic        cfg_wr;

    assign fac    = rng_reg == 2'h0 ? mirq_pkg::FACTOR_2G :
                    rng_reg == 2'h1 ? mirq_pkg::FACTOR_4G : mirq_pkg::FACTOR_8G;
    assign steady = age_reg == 2'h3;
    assign cfg_wr = i_wr_en && i_addr == mirq_pkg::ADDR_PIN_CONFIG;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            thr_reg  <= 8'h14;
            rng_reg  <= 2'h0;
            cfg_reg  <= 2'h1;
            hold_reg <= 4'h0;
            rte_reg  <= 1'b0;
            mrte_reg <= 1'b0;
            ren_reg  <= 1'b0;
            age_reg  <= 2'h0;
        end else begin
            age_reg <= i_wr_en ? 2'h0 : (steady ? age_reg : age_reg + 2'h1);
            if (i_wr_en && i_addr == mirq_pkg::ADDR_THRESHOLD) thr_reg <= i_wdata;
            if (i_wr_en && i_addr == mirq_pkg::ADDR_RANGE_SEL) rng_reg <= i_wdata[1:0];
            if (cfg_wr) cfg_reg <= i_wdata[1:0];
            if (i_wr_en && i_addr == mirq_pkg::ADDR_HOLD_TIME) hold_reg <= i_wdata[3:0];
            if (i_wr_en && i_addr == mirq_pkg::ADDR_READY_ROUTE) rte_reg <= i_wdata[0];
            if (i_wr_en && i_addr == mirq_pkg::ADDR_MOTION_ROUTE) mrte_reg <= i_wdata[2];
            if (i_wr_en && i_addr == mirq_pkg::ADDR_READY_EN) ren_reg <= i_wdata[4];
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence seq_quiet_clear;
        cfg_wr && i_wdata == 8'h81 && !i_new_data && !o_active
            ##1 (!i_new_data && !o_active) [*3];
    endsequence
    sequence seq_ready_routed;
        steady && ren_reg && rte_reg && cfg_reg == 2'h1 && i_new_data;
    endsequence

    chk_od_low: assert property (steady && cfg_reg[1] |-> !o_int_out)
        else $error("open drain pin drove high");
    chk_pp_drive: assert property (steady && !cfg_reg[1] |-> o_int_oe)
        else $error("push pull pin not driven");
    chk_ready_path: assert property (seq_ready_routed |=> o_int_out)
        else $error("routed new data missing on pin");
    chk_unrouted_idle: assert property (steady && !rte_reg && !mrte_reg && hold_reg == 4'h0
        && cfg_reg == 2'h1 |-> !o_int_out)
        else $error("unrouted source on pin");
    chk_perm_hold: assert property (steady && hold_reg[2:0] == 3'h7 && cfg_reg == 2'h1
        && o_int_out && !cfg_wr |=> o_int_out)
        else $error("permanent latch released");
    chk_clear_release: assert property (seq_quiet_clear |-> !o_int_out)
        else $error("clear did not release pin");
    chk_thr_scale: assert property (steady && rng_reg != 2'h3
        |-> o_thr_umg == 22'(thr_reg) * 22'(fac))
        else $error("threshold scale wrong");
    chk_active_cause: assert property ($rose(o_active) |-> $past(i_above_thr, 2))
        else $error("activity without condition");
endmodule

bind mirq_top mirq_chk i_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_rate_tick(i_rate_tick),
    .i_fast_tick(i_fast_tick), .i_new_data(i_new_data), .i_above_thr(i_above_thr),
    .o_rdata(o_rdata), .o_int_out(o_int_out), .o_int_oe(o_int_oe),
    .o_active(o_active), .o_inactive(o_inactive), .o_thr_umg(o_thr_umg));

// >>> testbench/mirq_host_model.sv
// host-side model of the interrupt wire: pull-up and level decode
`timescale 1ns/10ps
module mirq_host_model (
    input  wire logic i_out,
    input  wire logic i_oe,
    input  wire logic i_active_high,
    output logic      o_level,
    output logic      o_irq
);
    // ---------------------------------------------------------------
    // wire
    // ---------------------------------------------------------------
    // a released wire rises through the board pull-up
    assign o_level = i_oe ? i_out : 1'b1;
    assign o_irq   = o_level == i_active_high;
endmodule

// >>> testbench/testbench.sv
// testbench: register and interrupt pin scenarios for the interrupt block
`timescale 1ns/10ps
module testbench;
    logic        i_clk = 1'b0;
    logic        i_arst_n, i_wr_en, i_rd_en, i_rate_tick, i_fast_tick;
    logic        i_new_data, i_above_thr, o_int_out, o_int_oe, o_active, o_inactive;
    logic [7:0]  i_addr, i_wdata, o_rdata;
    logic [21:0] o_thr_umg;
    logic        act_high, pin_lvl, irq;
    logic [13:0] fac [3];
    int          error_cnt, checks;

    mirq_top i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_rate_tick(i_rate_tick),
        .i_fast_tick(i_fast_tick), .i_new_data(i_new_data), .i_above_thr(i_above_thr),
        .o_rdata(o_rdata), .o_int_out(o_int_out), .o_int_oe(o_int_oe),
        .o_active(o_active), .o_inactive(o_inactive), .o_thr_umg(o_thr_umg));
    mirq_host_model i_host (.i_out(o_int_out), .i_oe(o_int_oe),
        .i_active_high(act_high), .o_level(pin_lvl), .o_irq(irq));

    always #2.5 i_clk = ~i_clk;

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [21:0] seen, input logic [21:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr_en <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd_en <= 1'b1;
        i_addr  <= a;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        // read data stands for one cycle only
        #1;
        chk("rdata", o_rdata, exp);
    endtask
    task automatic tick(input logic f, input int n);
        repeat (n) begin
            @(posedge i_clk);
            i_fast_tick <= f;
            i_rate_tick <= !f;
            @(posedge i_clk);
            i_fast_tick <= 1'b0;
            i_rate_tick <= 1'b0;
        end
        wait_n(3);
    endtask
    task automatic nd(input logic v);
        @(posedge i_clk);
        i_new_data <= v;
    endtask

    // run is a few hundred cycles; the limit leaves wide margin
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end

    initial begin
        {i_arst_n, i_wr_en, i_rd_en, i_rate_tick, i_fast_tick} = 5'h00;
        {i_new_data, i_above_thr, i_addr, i_wdata} = 18'h00000;
        act_high = 1'b1;
        error_cnt = 0;
        checks = 0;
        fac = '{mirq_pkg::FACTOR_2G, mirq_pkg::FACTOR_4G, mirq_pkg::FACTOR_8G};
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd(8'h1a, 8'h00);
        rd(8'h20, 8'h01);
        rd(8'h21, 8'h00);
        rd(8'h27, 8'h00);
        rd(8'h28, 8'h14);
        rd(8'h30, 8'h00);
        chk("thr", o_thr_umg, 22'h013178);
        wr(8'h28, 8'hff);
        for (int c = 0; c < 3; c++) begin
            wr(8'h0f, 8'(c));
            wait_n(3);
            chk("thr", o_thr_umg, 22'(8'hff) * 22'(fac[c]));
        end
        wr(8'h17, 8'h10);
        nd(1'b1);
        wait_n(3);
        chk("irq", irq, 1'b0);
        nd(1'b0);
        wr(8'h1a, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(8'h20, 8'(c));
            act_high <= c[0];
            wait_n(3);
            chk("irq", irq, 1'b0);
            nd(1'b1);
            wait_n(3);
            chk("irq", irq, 1'b1);
            if (c[1]) chk("od_out", o_int_out, 1'b0);
            nd(1'b0);
            wait_n(3);
            chk("irq", irq, 1'b0);
            rd(8'h20, 8'(c));
        end
        wr(8'h20, 8'h01);
        for (int k = 0; k < 3; k++) begin
            wr(8'h21, k == 0 ? 8'h07 : (k == 1 ? 8'h0f : 8'h09));
            nd(1'b1);
            nd(1'b0);
            wait_n(8);
            chk("irq", irq, 1'b1);
            wr(8'h20, 8'h81);
            wait_n(3);
            chk("irq", irq, 1'b0);
        end
        rd(8'h20, 8'h01);
        wr(8'h21, 8'h00);
        wr(8'h1a, 8'h00);
        wr(8'h27, 8'h32);
        wr(8'h19, 8'h04);
        wr(8'h16, 8'h00);
        @(posedge i_clk) i_above_thr <= 1'b1;
        tick(1'b0, 3);
        chk("active", o_active, 1'b0);
        tick(1'b1, 2);
        chk("active", o_active, 1'b0);
        tick(1'b1, 1);
        chk("active", o_active, 1'b1);
        chk("irq", irq, 1'b1);
        rd(8'h09, 8'h04);
        wr(8'h16, 8'h40);
        @(posedge i_clk) i_above_thr <= 1'b0;
        tick(1'b0, 3);
        chk("inactive", o_inactive, 1'b0);
        tick(1'b1, 2);
        tick(1'b0, 1);
        chk("inactive", o_inactive, 1'b1);
        rd(8'h09, 8'h04);
        wr(8'h20, 8'h81);
        rd(8'h09, 8'h00);
        summarize();
    end
endmodule
